// file: inc/iac_pkg.sv
// Operation
// - A transmitting master that releases SDA but samples it low has lost.
// - Bitwise SDA comparison continues through every following byte until a difference.
// - On loss: stop driving, become slave receiver, set lost flag and request.
// - Arbitrating masters place repeated START or STOP at identical frame positions.
// - Module clock comes from the system clock through a programmable prescaler.
// - New prescale takes effect only when the module leaves reset.
// - SCL low lasts low count plus d, high lasts high count plus d.
// - Offset d is 7 for prescale 0, 6 for 1, else 5.
// - The generated clock reaches SCL only while configured as master.
// - An SCL low during our high count starts our own low count at once.
// - After the low count, wait for SCL really high before counting high.
// - A slave holding SCL low stalls the clock generator.
// - Events set their own flags; all merge into one CPU request.
// - Enable bit 0 blocks a flagged source, enable bit 1 forwards it.
// - Reading the source register clears that flag, except the three ready flags.
// - The three ready flags clear when software writes 1 to them.
// - After a source read, the next highest pending code is loaded and requested.
// - Sources: tx, rx, access ready, no ack, lost, stop, addressed slave.
package iac_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned MOD_CLK_MIN_MHZ = 7;
   localparam int unsigned MOD_CLK_MAX_MHZ = 12;
   localparam int ADDR_W = 8;
   localparam int DIV_W = 16;
   localparam int CNT_W = DIV_W + 1;
   localparam int NSRC = 7;
   // Register byte offsets.
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_PSC = 8'h04;
   localparam logic [7:0] OFS_CLKL = 8'h08;
   localparam logic [7:0] OFS_CLKH = 8'h0C;
   localparam logic [7:0] OFS_IEN = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_ISR = 8'h18;
   // Mode register bits.
   localparam int MODE_RUN = 0;
   localparam int MODE_MASTER = 1;
   localparam int MODE_TX = 2;
   // Source bit positions in status and enable registers.
   localparam int SRC_TX = 0;
   localparam int SRC_RX = 1;
   localparam int SRC_ACCESS = 2;
   localparam int SRC_NO_ACK = 3;
   localparam int SRC_ARB_LOST = 4;
   localparam int SRC_STOP = 5;
   localparam int SRC_ADDR = 6;
   localparam logic [NSRC-1:0] KEEP_MASK = 7'h07;
   // Source codes by bit position; a lower code wins.
   localparam logic [2:0] SRC_CODE [NSRC] = '{3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h6, 3'h7};
   localparam logic [3:0] D_PSC0 = 4'h7;
   localparam logic [3:0] D_PSC1 = 4'h6;
   localparam logic [3:0] D_OTHER = 4'h5;
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam logic [7:0] PSC_RST = 8'h00;
   localparam logic [DIV_W-1:0] CLKL_RST = 16'h0000;
   localparam logic [DIV_W-1:0] CLKH_RST = 16'h0000;
   localparam logic [NSRC-1:0] IEN_RST = 7'h00;
   localparam logic [2:0] SYNC_RST = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [1:0] {SCL_IDLE, SCL_LOW, SCL_WAIT, SCL_HIGH} iac_scl_st_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } iac_pin_t;

   typedef struct packed {
      logic addr_slave;
      logic stop_det;
      logic no_ack;
      logic access_ready;
      logic rx_ready;
      logic tx_ready;
   } iac_events_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [ADDR_W-1:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [2:0] mode;
      logic [7:0] psc;
      logic [DIV_W-1:0] clk_low;
      logic [DIV_W-1:0] clk_high;
      logic [NSRC-1:0] ien;
      logic [NSRC-1:0] flags;
      logic [2:0] isr_code;
      logic [NSRC-1:0] isr_hot;
      logic irq;
      logic slave_rx;
      logic [2:0] scl_sync;
      logic [2:0] sda_sync;
      logic scl_f;
      logic sda_f;
      logic scl_f_d;
      iac_scl_st_t scl_st;
      logic [CNT_W-1:0] cnt;
      iac_pin_t oe_n;
      iac_pin_t pin_o;
   } iac_state_t;
endpackage

// file: src/iac_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module iac_prescaler
   import iac_pkg::*;
#(
   parameter int PSC_W = 8
)(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic run,
   input wire logic [PSC_W-1:0] prescale_value,
   output logic tick,
   output logic [PSC_W-1:0] active_psc
);
   typedef struct packed {
      logic run_d;
      logic [PSC_W-1:0] active;
      logic [PSC_W-1:0] cnt;
      logic tick;
   } iac_psc_st_t;

   iac_psc_st_t r;
   iac_psc_st_t nx;

   // The value is captured only on the release edge, so a write while running waits.
   always_comb begin
      nx = r;
      nx.run_d = run;
      nx.tick = 1'b0;
      if (run && !r.run_d) begin
         nx.active = prescale_value;
         nx.cnt = '0;
      end else if (run) begin
         if (r.cnt >= r.active) begin
            nx.cnt = '0;
            nx.tick = 1'b1;
         end else begin
            nx.cnt = r.cnt + PSC_W'(1);
         end
      end else begin
         nx.cnt = '0;
      end
   end

   // Registered state.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= nx;
      end
   end

   assign tick = r.tick;
   assign active_psc = r.active;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_psc_frozen:
      assert property (run [*2] |=> $stable(r.active))
      else $error("Prescale changed while the module was running.");
   a_tick_spacing:
      assert property (r.tick && run && r.active != '0 |=> !r.tick)
      else $error("Module clock ticks came too close together.");
   a_tick_unity:
      assert property (r.tick && run && r.active == '0 |=> r.tick)
      else $error("Prescale zero did not tick every cycle.");
endmodule
`default_nettype wire

// file: src/iac_irq_arb.sv
`timescale 1ns/1ps
`default_nettype none
module iac_irq_arb
   import iac_pkg::*;
(
   input wire logic [NSRC-1:0] pending,
   output logic [2:0] code,
   output logic [NSRC-1:0] hot
);
   // Lowest code wins; an empty request set reports zero.
   always_comb begin
      code = 3'h0;
      hot = '0;
      for (int i = 0; i < NSRC; i++) begin
         if (pending[i] && (code == 3'h0 || SRC_CODE[i] < code)) begin
            code = SRC_CODE[i];
            hot = NSRC'(1) << i;
         end
      end
   end
endmodule
`default_nettype wire

// file: src/iac_top.sv
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module iac_top
   import iac_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire iac_events_t ev,
   input wire logic data_bit_phase,
   input wire logic tx_bit,
   input wire iac_pin_t pin_i,
   output iac_pin_t pin_o,
   output iac_pin_t pin_oe_n,
   output logic irq,
   output logic slave_rx,
   output logic run
);
   iac_state_t r;
   iac_state_t nx;
   logic tick;
   logic [7:0] act_psc;
   logic [3:0] d_off;
   logic [CNT_W-1:0] low_target;
   logic [CNT_W-1:0] high_target;
   logic gen_on;
   logic want_hi;
   logic scl_rise;
   logic lost;
   logic wr_fire;
   logic rd_fire;
   logic rd_isr;
   logic [NSRC-1:0] ev_vec;
   logic [NSRC-1:0] pending;
   logic [NSRC-1:0] w1c_bits;
   logic [2:0] arb_code;
   logic [NSRC-1:0] arb_hot;
   logic [31:0] wr_word;

   // Word seen by software at a given offset; unmapped offsets read zero.
   function automatic logic [31:0] reg_view(input iac_state_t s, input logic [ADDR_W-1:0] a);
      logic [31:0] v;
      v = 32'h0;
      case (a)
         OFS_MODE: v = {29'h0, s.mode};
         OFS_PSC: v = {24'h0, s.psc};
         OFS_CLKL: v = {16'h0, s.clk_low};
         OFS_CLKH: v = {16'h0, s.clk_high};
         OFS_IEN: v = {25'h0, s.ien};
         OFS_STATUS: v = {21'h0, s.sda_f, s.scl_f, s.slave_rx, 1'b0, s.flags};
         OFS_ISR: v = {29'h0, s.isr_code};
         default: v = 32'h0;
      endcase
      return v;
   endfunction

   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      logic ok;
      ok = 1'b0;
      case (a)
         OFS_MODE, OFS_PSC, OFS_CLKL, OFS_CLKH, OFS_IEN, OFS_STATUS, OFS_ISR: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // Byte lanes not strobed keep their old contents.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                         input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[8*i +: 8] = val[8*i +: 8];
         end
      end
      return res;
   endfunction

   iac_prescaler #(
      .PSC_W(8)
   ) u_psc (
      .clk(clk),
      .sys_rst(sys_rst),
      .run(r.mode[MODE_RUN]),
      .prescale_value(r.psc),
      .tick(tick),
      .active_psc(act_psc)
   );

   iac_irq_arb u_arb (
      .pending(pending),
      .code(arb_code),
      .hot(arb_hot)
   );

   // The offset follows the prescale actually in use, not the one last written.
   assign d_off = (act_psc == 8'h00) ? D_PSC0 : (act_psc == 8'h01) ? D_PSC1 : D_OTHER;
   assign low_target = CNT_W'(r.clk_low) + CNT_W'(d_off);
   assign high_target = CNT_W'(r.clk_high) + CNT_W'(d_off);
   assign gen_on = r.mode[MODE_RUN] && r.mode[MODE_MASTER];

   // Arbitration samples SDA at each rising SCL of a data bit while we send a one.
   // Start and stop are not compared, since all contenders place them alike.
   assign want_hi = gen_on && r.mode[MODE_TX] && data_bit_phase && tx_bit;
   assign scl_rise = r.scl_f && !r.scl_f_d;
   assign lost = want_hi && scl_rise && !r.sda_f;

   // Bus strobes and event collection.
   assign wr_fire = r.aw_got && r.w_got && !r.bvalid;
   assign rd_fire = s_axi_arvalid && r.arready;
   assign rd_isr = rd_fire && s_axi_araddr == OFS_ISR;
   assign ev_vec = {ev.addr_slave, ev.stop_det, lost, ev.no_ack,
                    ev.access_ready, ev.rx_ready, ev.tx_ready};
   assign pending = r.flags & r.ien;
   assign w1c_bits = r.wdata[NSRC-1:0] & {NSRC{r.wstrb[0]}} & KEEP_MASK;
   assign wr_word = merge(reg_view(r, r.awaddr), r.wdata, r.wstrb);

   // Next state of the whole block.
   always_comb begin
      logic [NSRC-1:0] clr;
      clr = '0;
      nx = r;

      // Write channel: address and data are taken in either order.
      if (s_axi_awvalid && r.awready) begin
         nx.aw_got = 1'b1;
         nx.awready = 1'b0;
         nx.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && r.wready) begin
         nx.w_got = 1'b1;
         nx.wready = 1'b0;
         nx.wdata = s_axi_wdata;
         nx.wstrb = s_axi_wstrb;
      end
      if (wr_fire) begin
         nx.aw_got = 1'b0;
         nx.w_got = 1'b0;
         nx.bvalid = 1'b1;
         nx.bresp = addr_ok(r.awaddr) ? RESP_OKAY : RESP_DECERR;
         case (r.awaddr)
            OFS_MODE: begin
               nx.mode = wr_word[2:0];
               if (wr_word[MODE_MASTER]) begin
                  nx.slave_rx = 1'b0;
               end
            end
            OFS_PSC: nx.psc = wr_word[7:0];
            OFS_CLKL: nx.clk_low = wr_word[DIV_W-1:0];
            OFS_CLKH: nx.clk_high = wr_word[DIV_W-1:0];
            OFS_IEN: nx.ien = wr_word[NSRC-1:0];
            OFS_STATUS: clr = clr | w1c_bits;
            default: nx.bresp = addr_ok(r.awaddr) ? RESP_OKAY : RESP_DECERR;
         endcase
      end
      if (r.bvalid && s_axi_bready) begin
         nx.bvalid = 1'b0;
         nx.awready = 1'b1;
         nx.wready = 1'b1;
      end

      // Read channel: data is captured at the address handshake.
      if (rd_fire) begin
         nx.arready = 1'b0;
         nx.rvalid = 1'b1;
         nx.rdata = reg_view(r, s_axi_araddr);
         nx.rresp = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      end
      if (r.rvalid && s_axi_rready) begin
         nx.rvalid = 1'b0;
         nx.arready = 1'b1;
      end

      // A source read clears only the reported source; ready flags need a write.
      if (rd_isr) begin
         clr = clr | (r.isr_hot & ~KEEP_MASK);
      end
      // Setting after clearing lets an event in the clearing cycle survive.
      nx.flags = (r.flags & ~clr) | ev_vec;
      nx.isr_code = arb_code;
      nx.isr_hot = arb_hot;
      // The request drops for the read cycle, then returns if anything pends.
      nx.irq = (|pending) && !rd_isr;

      // Losing hands the bus over: master and transmit drop, receive as slave.
      if (lost) begin
         nx.mode[MODE_MASTER] = 1'b0;
         nx.mode[MODE_TX] = 1'b0;
         nx.slave_rx = 1'b1;
      end
      if (!nx.mode[MODE_RUN]) begin
         nx.slave_rx = 1'b0;
      end

      // Pin inputs: the first stage only feeds the second.
      nx.scl_sync = {r.scl_sync[1:0], pin_i.scl};
      nx.sda_sync = {r.sda_sync[1:0], pin_i.sda};
      if (r.scl_sync[2] == r.scl_sync[1]) begin
         nx.scl_f = r.scl_sync[2];
      end
      if (r.sda_sync[2] == r.sda_sync[1]) begin
         nx.sda_f = r.sda_sync[2];
      end
      nx.scl_f_d = r.scl_f;

      // Master clock generator counting module clock ticks.
      case (r.scl_st)
         SCL_IDLE: begin
            if (gen_on) begin
               nx.scl_st = SCL_LOW;
               nx.cnt = low_target;
            end
         end
         SCL_LOW: begin
            if (tick) begin
               if (r.cnt <= CNT_W'(1)) begin
                  nx.scl_st = SCL_WAIT;
               end else begin
                  nx.cnt = r.cnt - CNT_W'(1);
               end
            end
         end
         SCL_WAIT: begin
            // A slave holding the line keeps us here as long as it likes.
            if (r.scl_f) begin
               nx.scl_st = SCL_HIGH;
               nx.cnt = high_target;
            end
         end
         SCL_HIGH: begin
            if (!r.scl_f) begin
               nx.scl_st = SCL_LOW;
               nx.cnt = low_target;
            end else if (tick) begin
               if (r.cnt <= CNT_W'(1)) begin
                  nx.scl_st = SCL_LOW;
                  nx.cnt = low_target;
               end else begin
                  nx.cnt = r.cnt - CNT_W'(1);
               end
            end
         end
         default: nx.scl_st = SCL_IDLE;
      endcase
      if (!gen_on || lost) begin
         nx.scl_st = SCL_IDLE;
      end

      // Open-drain drive: enable low pulls the wire low.
      nx.oe_n.scl = (nx.scl_st != SCL_LOW);
      nx.oe_n.sda = !(nx.mode[MODE_RUN] && nx.mode[MODE_MASTER] && nx.mode[MODE_TX] &&
                      data_bit_phase && !tx_bit);
      nx.pin_o = '0;
   end

   // Registered state; the pin stages reset to an idle high bus.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r <= '0;
         r.awready <= 1'b1;
         r.wready <= 1'b1;
         r.arready <= 1'b1;
         r.mode <= MODE_RST;
         r.psc <= PSC_RST;
         r.clk_low <= CLKL_RST;
         r.clk_high <= CLKH_RST;
         r.ien <= IEN_RST;
         r.scl_sync <= SYNC_RST;
         r.sda_sync <= SYNC_RST;
         r.scl_f <= 1'b1;
         r.sda_f <= 1'b1;
         r.scl_f_d <= 1'b1;
         r.scl_st <= SCL_IDLE;
         r.oe_n <= '1;
      end else begin
         r <= nx;
      end
   end

   // All outputs come straight from the state register.
   assign s_axi_awready = r.awready;
   assign s_axi_wready = r.wready;
   assign s_axi_bresp = r.bresp;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_arready = r.arready;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign s_axi_rvalid = r.rvalid;
   assign pin_o = r.pin_o;
   assign pin_oe_n = r.oe_n;
   assign irq = r.irq;
   assign slave_rx = r.slave_rx;
   assign run = r.mode[MODE_RUN];

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_overruled;
      want_hi && scl_rise && !r.sda_f;
   endsequence

   sequence s_low_entry;
      (r.scl_st != SCL_LOW) ##1 (r.scl_st == SCL_LOW && $stable(r.clk_low) && $stable(act_psc));
   endsequence

   a_arb_overrule:
      assert property (s_overruled |=> r.flags[SRC_ARB_LOST])
      else $error("Overrule did not set the lost flag.");
   a_arb_release:
      assert property (s_overruled |=> !r.mode[MODE_MASTER] && r.slave_rx && r.oe_n.scl)
      else $error("Lost master kept driving or did not turn slave receiver.");
   a_arb_continue:
      assert property (want_hi && scl_rise && r.sda_f && !wr_fire |=> r.mode[MODE_MASTER])
      else $error("Master gave up although SDA matched.");
   a_scl_slave:
      assert property (!gen_on |=> r.oe_n.scl)
      else $error("SCL driven while not master.");
   a_scl_sync_low:
      assert property (r.scl_st == SCL_HIGH && !r.scl_f && gen_on && !lost
                       |=> r.scl_st == SCL_LOW && !r.oe_n.scl)
      else $error("Low period did not start on a foreign SCL low.");
   a_scl_wait_high:
      assert property ((r.scl_st == SCL_LOW) ##1 (r.scl_st != SCL_LOW && r.scl_st != SCL_IDLE)
                       |-> r.scl_st == SCL_WAIT)
      else $error("High count began without seeing SCL high.");
   a_scl_stall:
      assert property (r.scl_st == SCL_WAIT && !r.scl_f && gen_on |=> r.scl_st == SCL_WAIT)
      else $error("Clock generator ran on while SCL was held low.");
   a_low_load:
      assert property (s_low_entry |-> r.cnt == low_target)
      else $error("Low period loaded with the wrong count.");
   a_irq_masked:
      assert property (pending == 7'h00 |=> !r.irq)
      else $error("Interrupt raised with no enabled flag.");
   a_irq_forward:
      assert property (pending != 7'h00 && !rd_isr |=> r.irq)
      else $error("Enabled flag did not reach the interrupt output.");
   a_isr_clear:
      assert property (rd_isr && (r.isr_hot & ~KEEP_MASK & ev_vec) == 7'h00
                       |=> (r.flags & $past(r.isr_hot) & ~KEEP_MASK) == 7'h00)
      else $error("Source read did not clear the reported flag.");
   a_ready_w1c:
      assert property (wr_fire && r.awaddr == OFS_STATUS && ev_vec == 7'h00
                       |=> (r.flags & $past(w1c_bits)) == 7'h00)
      else $error("Write of one did not clear a ready flag.");
   a_isr_empty:
      assert property (pending == 7'h00 |=> r.isr_code == 3'h0)
      else $error("Source code not zero with nothing pending.");
endmodule
`default_nettype wire

// file: test/iac_bus_peer.sv
`timescale 1ns/1ps
`default_nettype none
// Far side of the bus: pull-ups, a slow slave on SCL and a rival master on SDA.
module iac_bus_peer
   import iac_pkg::*;
(
   input wire logic clk,
   input wire iac_pin_t dut_oe_n,
   input wire logic [7:0] stretch,
   input wire logic pull_sda,
   output iac_pin_t bus
);
   logic [7:0] cnt = 8'h00;
   logic scl_d = 1'b1;
   logic rival = 1'b0;
   // Released lines go to the pull-up level, never to a remembered value.
   assign bus.scl = dut_oe_n.scl & (cnt == 8'h00);
   assign bus.sda = dut_oe_n.sda & !rival;
   // Every SCL fall is held low for the stretch count, as a slow slave does.
   always_ff @(posedge clk) begin
      scl_d <= bus.scl;
      if (scl_d && !bus.scl) begin
         cnt <= stretch;
      end else if (cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
      end
      // The rival starts pulling SDA only while SCL is low, so it never fakes a START.
      if (!pull_sda) begin
         rival <= 1'b0;
      end else if (!bus.scl) begin
         rival <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: test/iac_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module iac_top_test
   import iac_pkg::*;
;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [ADDR_W-1:0] s_axi_awaddr = '0;
   logic [ADDR_W-1:0] s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic data_bit_phase = 1'b0, tx_bit = 1'b0, pull_sda = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic irq, slave_rx, run;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, rd;
   logic [7:0] stretch = 8'h00;
   iac_events_t ev = '0;
   iac_pin_t pin_i, pin_o, pin_oe_n;
   int errors = 0, checked = 0, n, s, e;
   int codes [4] = '{2, 6, 7, 0};
   int pscs [3] = '{8, 10, 13};

   iac_top uut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ev, .data_bit_phase,
      .tx_bit, .pin_i, .pin_o, .pin_oe_n, .irq, .slave_rx, .run);
   iac_bus_peer peer (.clk, .dut_oe_n(pin_oe_n), .stretch, .pull_sda, .bus(pin_i));

   // Free-running 100 MHz clock.
   initial forever #5 clk = ~clk;

   task automatic end_of_test();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input int got, input int lo, input int hi);
      checked++;
      if (got < lo || got > hi) begin
         errors++;
         $display("wrong value at %0t: span %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask

   task automatic tick();
      @(posedge clk);
      n++;
   endtask

   // Both write channels rise together; each drops once its ready is seen at an edge.
   // The trailing edge keeps a following call from touching a strobe twice in one step.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin
         tick();
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      resp = s_axi_bresp;
      if (s_axi_bvalid !== 1'b1) begin
         errors++;
         $display("wrong value at %0t: write got no response", $time);
      end
      s_axi_bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] x);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
         tick();
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      if (s_axi_rvalid !== 1'b1) begin
         errors++;
         $display("wrong value at %0t: read got no response", $time);
      end
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      chk(rd, x);
   endtask

   task automatic pulse(input logic [5:0] v);
      ev <= v;
      @(posedge clk);
      ev <= '0;
      repeat (3) @(posedge clk);
   endtask

   // Low time of the wire (w=1) or of our own drive, skipping a phase already running.
   task automatic span(input bit w, output int c);
      c = 0;
      n = 0;
      while ((w ? pin_i.scl : pin_oe_n.scl) !== 1'b1 && n < 500) tick();
      while ((w ? pin_i.scl : pin_oe_n.scl) !== 1'b0 && n < 500) tick();
      while ((w ? pin_i.scl : pin_oe_n.scl) === 1'b0 && n < 500) begin
         tick();
         c++;
      end
   endtask

   // Main sequence.
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rchk(OFS_MODE, 32'h0);
      rchk(OFS_ISR, 32'h0);
      rchk(8'h40, 32'h0);
      chk(resp, RESP_DECERR);
      wr(8'h40, 32'h1);
      chk(resp, RESP_DECERR);
      wr(OFS_CLKL, 32'h2);
      wr(OFS_CLKH, 32'h2);
      chk(resp, RESP_OKAY);
      // Only prescales that keep the module clock legal at a 100 MHz system clock.
      foreach (pscs[i]) begin
         wr(OFS_MODE, 32'h0);
         wr(OFS_PSC, pscs[i]);
         wr(OFS_MODE, 32'h3);
         span(0, s);
         span(0, s);
         e = (2 + D_OTHER) * (pscs[i] + 1);
         chk_rng(s, e - pscs[i], e + 1);
      end
      // A prescale write while running must wait for the next release.
      wr(OFS_PSC, 32'h8);
      span(0, s);
      chk_rng(s, 85, 99);
      wr(OFS_MODE, 32'h0);
      wr(OFS_MODE, 32'h3);
      chk(run, 1'b1);
      span(0, s);
      chk_rng(s, 55, 64);
      wr(OFS_MODE, 32'h1);
      span(0, s);
      chk(s, 0);
      // The stretch must outlast our own low phase to show on the wire.
      stretch <= 8'h78;
      wr(OFS_MODE, 32'h3);
      span(0, s);
      chk_rng(s, 55, 64);
      span(1, s);
      chk_rng(s, 120, 123);
      n = 0;
      while (pin_oe_n.scl !== 1'b0 && n < 100) tick();
      chk_rng(n, 59, 69);
      stretch <= 8'h00;
      wr(OFS_IEN, 32'h7F);
      wr(OFS_MODE, 32'h7);
      data_bit_phase <= 1'b1;
      repeat (40) @(posedge clk);
      chk(pin_oe_n.sda, 1'b0);
      // The datapath changes SDA only at the start of a low phase, never near a rise.
      n = 0;
      while (pin_oe_n.scl !== 1'b1 && n < 500) tick();
      while (pin_oe_n.scl !== 1'b0 && n < 500) tick();
      tx_bit <= 1'b1;
      repeat (150) @(posedge clk);
      chk(slave_rx, 1'b0);
      pull_sda <= 1'b1;
      n = 0;
      while (slave_rx !== 1'b1 && n < 400) tick();
      chk(slave_rx, 1'b1);
      chk(pin_oe_n, 2'b11);
      chk(pin_o, 2'b00);
      repeat (3) @(posedge clk);
      chk(irq, 1'b1);
      rchk(OFS_MODE, 32'h1);
      rchk(OFS_ISR, 32'h1);
      rchk(OFS_ISR, 32'h0);
      pull_sda <= 1'b0;
      data_bit_phase <= 1'b0;
      pulse(6'h38);
      chk(irq, 1'b1);
      foreach (codes[i]) rchk(OFS_ISR, codes[i]);
      wr(OFS_IEN, 32'h0);
      pulse(6'h04);
      chk(irq, 1'b0);
      rchk(OFS_STATUS, 32'h704);
      wr(OFS_IEN, 32'h7F);
      chk(irq, 1'b1);
      rchk(OFS_ISR, 32'h3);
      rchk(OFS_ISR, 32'h3);
      wr(OFS_STATUS, 32'h4);
      rchk(OFS_ISR, 32'h0);
      pulse(6'h03);
      rchk(OFS_ISR, 32'h4);
      wr(OFS_STATUS, 32'h2);
      rchk(OFS_ISR, 32'h5);
      wr(OFS_STATUS, 32'h1);
      rchk(OFS_ISR, 32'h0);
      chk(irq, 1'b0);
      end_of_test();
   end

   // The sequence needs about 3500 cycles; seven times that means a hang.
   initial begin
      repeat (25000) @(posedge clk);
      errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
